// ### shared/smc_defs.vh
`ifndef SMC_DEFS_VH
`define SMC_DEFS_VH

// APB register byte addresses
`define SMC_ADDR_MAIN       12'h000
`define SMC_ADDR_EXT        12'h004
`define SMC_ADDR_STATUS     12'h008

// Bank address values that select a configuration register on load
`define SMC_BANK_MAIN       3'h0
`define SMC_BANK_EXT        3'h1

// Main configuration register fields
`define SMC_MAIN_WIDTH      13
`define SMC_RL_LSB          4
`define SMC_RL_MSB          6
`define SMC_DLL_RST_BIT     8
`define SMC_WR_LSB          9
`define SMC_WR_MSB          11
`define SMC_PD_SEL_BIT      12

// Extended configuration register fields
`define SMC_EXT_WIDTH       13
`define SMC_LOOP_EN_BIT     0
`define SMC_DRIVE_BIT       1
`define SMC_TERM_LO_BIT     2
`define SMC_PD_LSB          3
`define SMC_PD_MSB          5
`define SMC_TERM_HI_BIT     6
`define SMC_STROBE_N_BIT    10
`define SMC_RCOPY_BIT       11
`define SMC_OUT_DIS_BIT     12

// Reset values
`define SMC_MAIN_RESET      13'h0000
`define SMC_EXT_RESET       13'h0000

// Termination selection codes {high, low}
`define SMC_TERM_OFF        2'h0
`define SMC_TERM_75         2'h1
`define SMC_TERM_150        2'h2
`define SMC_TERM_50         2'h3

// Timing counts in clocks
`define SMC_DLL_LOCK_CYC    200
`define SMC_FAST_EXIT_CYC   2
`define SMC_SLOW_EXIT_CYC   7
`define SMC_HIST_WIDTH      16

`endif

// ### src/smc_config.v
// The address map and register access over APB were left to the implementer.
`timescale 1ns/10ps
`include "smc_defs.vh"

// Overview of operation
// - Loading a one into dll_reset_bit starts a DLL reset; the bit self-clears.
// - Auto-precharge after write waits the programmed recovery clocks after last data.
// - Select bit clear: active power-down uses fast exit, DLL keeps running.
// - Select bit set: active power-down uses slow exit, DLL frozen.
// - Precharge power-down ignores the exit select bit.
// - Read latency field gives 3 to 7 whole clocks; reserved codes unused.
// - With zero posted delay, first read data appears latency clocks after command.
// - Early reads are held posted delay clocks before internal issue.
// - Configuration registers hold until reloaded, except the self-clearing dll_reset_bit; reloading touches no array data.
// - DLL turns off in self refresh, returns and resets on exit.
// - Drive strength bit selects full drive at zero, reduced at one.
// - Complement strobe bit one disables both complement strobe pins.
// - Read strobe copy bit set mirrors data strobe drive; reads and writes are not decoded.
// - Output disable bit set turns off every data and strobe output.
// - Two bits choose 50, 75 or 150 ohm termination; reserved unused.
// - Termination pin acts only in active and power-down states when enabled; here only self refresh blocks it.
// - Posted delay field 0 to 6; read latency adds it, write one less.
module smc_config #(
    parameter DLL_LOCK_CYC = `SMC_DLL_LOCK_CYC,
    parameter FAST_EXIT_CYC = `SMC_FAST_EXIT_CYC,
    parameter SLOW_EXIT_CYC = `SMC_SLOW_EXIT_CYC
)(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire load_config_cmd,
    input wire [2:0] cmd_bank,
    input wire [12:0] cmd_addr,
    input wire cmd_read,
    input wire cmd_write,
    input wire wr_ap_last,
    input wire self_refresh,
    input wire active_pd,
    input wire precharge_pd,
    input wire data_drive,
    input wire termination_ctrl_pin,
    output reg dll_enabled,
    output reg dll_reset_pulse,
    output wire dll_locked,
    output reg dll_frozen,
    output reg precharge_start,
    output wire read_issue,
    output wire read_data_start,
    output wire write_data_start,
    output wire exit_busy,
    output reg drive_reduced,
    output reg dq_oe,
    output reg dqs_oe,
    output reg dqs_n_oe,
    output reg rcopy_oe,
    output reg rcopy_n_oe,
    output reg [1:0] effective_termination,
    output reg termination_on
);

    // ************************************************************
    // Configuration registers
    // ************************************************************
    reg [12:0] main_config_reg;
    reg [12:0] extended_config_reg;
    wire apb_write;
    wire apb_hit;
    wire load_main;
    wire load_ext;
    wire [12:0] load_value;

    // Reserved codes are stored as written; the controller must avoid them
    assign apb_write = psel & penable & pwrite;
    assign apb_hit = (paddr == `SMC_ADDR_MAIN) || (paddr == `SMC_ADDR_EXT)
        || (paddr == `SMC_ADDR_STATUS);
    // A load command from the controller wins over a software write
    assign load_main = (load_config_cmd && cmd_bank == `SMC_BANK_MAIN)
        || (!load_config_cmd && apb_write && paddr == `SMC_ADDR_MAIN);
    assign load_ext = (load_config_cmd && cmd_bank == `SMC_BANK_EXT)
        || (!load_config_cmd && apb_write && paddr == `SMC_ADDR_EXT);
    assign load_value = load_config_cmd ? cmd_addr : pwdata[12:0];

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            main_config_reg <= `SMC_MAIN_RESET;
            extended_config_reg <= `SMC_EXT_RESET;
        end
        else
        begin
            if (load_main)
                main_config_reg <= load_value;
            else
                main_config_reg[`SMC_DLL_RST_BIT] <= 1'b0;
            if (load_ext)
                extended_config_reg <= load_value;
        end
    end

    wire dll_reset_bit;
    wire [2:0] write_recovery_field;
    wire powerdown_exit_select;
    wire [2:0] read_latency_field;
    wire [2:0] posted_delay_field;
    wire loop_enable_bit;
    wire strobe_complement_disable;
    wire read_strobe_copy_enable;
    wire output_disable_bit;
    wire [1:0] term_sel;

    assign dll_reset_bit = main_config_reg[`SMC_DLL_RST_BIT];
    assign write_recovery_field = main_config_reg[`SMC_WR_MSB:`SMC_WR_LSB];
    assign powerdown_exit_select = main_config_reg[`SMC_PD_SEL_BIT];
    assign read_latency_field = main_config_reg[`SMC_RL_MSB:`SMC_RL_LSB];
    assign posted_delay_field = extended_config_reg[`SMC_PD_MSB:`SMC_PD_LSB];
    // Low level enables the loop, so a cleared register leaves it running
    assign loop_enable_bit = ~extended_config_reg[`SMC_LOOP_EN_BIT];
    assign strobe_complement_disable = extended_config_reg[`SMC_STROBE_N_BIT];
    assign read_strobe_copy_enable = extended_config_reg[`SMC_RCOPY_BIT];
    assign output_disable_bit = extended_config_reg[`SMC_OUT_DIS_BIT];
    assign term_sel = {extended_config_reg[`SMC_TERM_HI_BIT],
        extended_config_reg[`SMC_TERM_LO_BIT]};

    // ************************************************************
    // DLL control and lock counter
    // ************************************************************
    reg self_refresh_q;
    // Eight bits only: a lock count above 255 needs a wider counter
    reg [7:0] lock_count;
    wire sr_exit;
    wire start_dll_reset;

    // Leaving self refresh resets the loop just as a load would
    assign sr_exit = self_refresh_q & ~self_refresh;
    assign start_dll_reset = dll_reset_bit | sr_exit;
    assign dll_locked = (lock_count == 8'h00) && dll_enabled;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            self_refresh_q <= 1'b0;
            dll_enabled <= 1'b0;
            dll_reset_pulse <= 1'b0;
            lock_count <= 8'h00;
        end
        else
        begin
            self_refresh_q <= self_refresh;
            dll_enabled <= loop_enable_bit & ~self_refresh;
            dll_reset_pulse <= start_dll_reset;
            // Status only: the controller owns the wait before reads
            if (start_dll_reset)
                lock_count <= DLL_LOCK_CYC[7:0];
            else if (lock_count != 8'h00)
                lock_count <= lock_count - 8'h01;
        end
    end

    // ************************************************************
    // Write recovery before auto precharge
    // ************************************************************
    // A new burst end restarts the count, dropping an earlier precharge unless its count has already reached one
    reg [3:0] wr_count;
    wire [3:0] wr_clocks;

    // Code 1..7 gives 2..8 clocks; code 0 is reserved
    assign wr_clocks = {1'b0, write_recovery_field} + 4'h1;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_count <= 4'h0;
            precharge_start <= 1'b0;
        end
        else
        begin
            precharge_start <= (wr_count == 4'h1);
            if (wr_ap_last)
                wr_count <= wr_clocks;
            else if (wr_count != 4'h0)
                wr_count <= wr_count - 4'h1;
        end
    end

    // ************************************************************
    // Power-down exit timing
    // ************************************************************
    reg active_pd_q;
    reg precharge_pd_q;
    reg [3:0] exit_count;

    // Each exit reloads the timer, so a quick second exit stretches it
    assign exit_busy = (exit_count != 4'h0);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            active_pd_q <= 1'b0;
            precharge_pd_q <= 1'b0;
            exit_count <= 4'h0;
            dll_frozen <= 1'b0;
        end
        else
        begin
            active_pd_q <= active_pd;
            precharge_pd_q <= precharge_pd;
            dll_frozen <= active_pd & powerdown_exit_select;
            if (active_pd_q && !active_pd)
            begin
                if (powerdown_exit_select)
                    exit_count <= SLOW_EXIT_CYC[3:0];
                else
                    exit_count <= FAST_EXIT_CYC[3:0];
            end
            else if (precharge_pd_q && !precharge_pd)
                exit_count <= FAST_EXIT_CYC[3:0];
            else if (exit_count != 4'h0)
                exit_count <= exit_count - 4'h1;
        end
    end

    // ************************************************************
    // Read and write latency pipeline
    // ************************************************************
    reg [`SMC_HIST_WIDTH-1:0] read_hist;
    reg [`SMC_HIST_WIDTH-1:0] write_hist;
    wire [3:0] read_lat;
    wire [3:0] write_lat;

    // Sixteen entries cover the longest latency of thirteen clocks
    // Changing a latency with commands in flight retimes them
    // Bit k of a history holds the command seen k edges ago
    assign read_lat = {1'b0, posted_delay_field} + {1'b0, read_latency_field};
    assign write_lat = read_lat - 4'h1;
    assign read_issue = read_hist[posted_delay_field];
    assign read_data_start = read_hist[read_lat];
    assign write_data_start = write_hist[write_lat];

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            read_hist <= {`SMC_HIST_WIDTH{1'b0}};
            write_hist <= {`SMC_HIST_WIDTH{1'b0}};
        end
        else
        begin
            read_hist <= {read_hist[`SMC_HIST_WIDTH-2:0], cmd_read};
            write_hist <= {write_hist[`SMC_HIST_WIDTH-2:0], cmd_write};
        end
    end

    // ************************************************************
    // Output drivers and termination
    // ************************************************************
    // Two flops tame the asynchronous termination pin
    reg odt_meta;
    reg odt_sync;
    wire outputs_live;

    // Enables are registered, so they follow their cause by one clock
    assign outputs_live = data_drive & ~output_disable_bit;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            odt_meta <= 1'b0;
            odt_sync <= 1'b0;
            drive_reduced <= 1'b0;
            dq_oe <= 1'b0;
            dqs_oe <= 1'b0;
            dqs_n_oe <= 1'b0;
            rcopy_oe <= 1'b0;
            rcopy_n_oe <= 1'b0;
            effective_termination <= `SMC_TERM_OFF;
            termination_on <= 1'b0;
        end
        else
        begin
            odt_meta <= termination_ctrl_pin;
            odt_sync <= odt_meta;
            drive_reduced <= extended_config_reg[`SMC_DRIVE_BIT];
            dq_oe <= outputs_live;
            dqs_oe <= outputs_live;
            dqs_n_oe <= outputs_live & ~strobe_complement_disable;
            // Copy strobe follows data drive and the copy bit; reads and writes are not decoded
            rcopy_oe <= outputs_live & read_strobe_copy_enable;
            rcopy_n_oe <= outputs_live & read_strobe_copy_enable
                & ~strobe_complement_disable;
            effective_termination <= term_sel;
            termination_on <= odt_sync && (term_sel != `SMC_TERM_OFF)
                && !self_refresh;
        end
    end

    // ************************************************************
    // APB slave
    // ************************************************************
    // Status word packs the timers and loop state for software
    wire [31:0] status_word;

    // No wait states: every access ends in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~apb_hit;
    assign status_word = {20'h00000, exit_count, termination_on, dll_frozen,
        exit_busy, wr_count != 4'h0, dll_locked, lock_count != 8'h00,
        self_refresh_q, dll_enabled};

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        // Captured in setup so the data stands through the access cycle
        else if (psel && !penable)
        begin
            case (paddr)
                `SMC_ADDR_MAIN: prdata <= {19'h00000, main_config_reg};
                `SMC_ADDR_EXT: prdata <= {19'h00000, extended_config_reg};
                `SMC_ADDR_STATUS: prdata <= status_word;
                default: prdata <= 32'h00000000;
            endcase
        end
    end

endmodule

// ### test/smc_ctl_model.sv
`timescale 1ns/10ps
// ****
// Controller side of the command bus
// ****
module smc_ctl_model #(
    parameter LOCK = 5
)(
    input wire pclk,
    output reg load_config_cmd = 1'b0,
    output reg [2:0] cmd_bank = 3'h0,
    output reg [12:0] cmd_addr = 13'h0,
    output reg cmd_read = 1'b0,
    output reg cmd_write = 1'b0,
    output reg wr_ap_last = 1'b0
);
    task automatic load(input [2:0] b, input [12:0] v);
        @(posedge pclk);
        {load_config_cmd, cmd_bank, cmd_addr} <= {1'b1, b, v};
        @(posedge pclk);
        // Stale address must not look valid
        {load_config_cmd, cmd_addr} <= {1'b0, ~v};
        repeat (2) @(posedge pclk);
        if (b == 3'h0 && v[8])
            repeat (LOCK) @(posedge pclk);
    endtask
    // No refresh is issued and the clock is far above 25 MHz
    task automatic pulse(input int s);
        @(posedge pclk);
        {cmd_read, cmd_write, wr_ap_last} <= {s < 2, s == 2, s == 3};
        @(posedge pclk);
        {cmd_read, cmd_write, wr_ap_last} <= 3'h0;
    endtask
endmodule

// ### test/smc_config_assertions.sv
`timescale 1ns/10ps
// ****
// Port checks
// ****
module smc_config_assertions #(
    parameter DLL_LOCK_CYC = 200
)(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire load_config_cmd,
    input wire [2:0] cmd_bank,
    input wire [12:0] cmd_addr,
    input wire cmd_read,
    input wire wr_ap_last,
    input wire active_pd,
    input wire precharge_pd,
    input wire data_drive,
    input wire dll_reset_pulse,
    input wire dll_locked,
    input wire precharge_start,
    input wire read_issue,
    input wire read_data_start,
    input wire exit_busy,
    input wire dq_oe,
    input wire dqs_n_oe,
    input wire rcopy_n_oe
);
    reg [12:0] m_q;
    reg [12:0] e_q;
    reg [15:0] q_is;
    reg [15:0] q_rd;
    reg [15:0] q_pc;
    reg [7:0] since;
    wire [3:0] al = {1'b0, e_q[5:3]};
    wire [3:0] rl = al + {1'b0, m_q[6:4]};
    wire [3:0] wr = {1'b0, m_q[11:9]} + 4'h1;
    wire [2:0] oe_x = {3{data_drive & ~e_q[12]}} & {1'b1, ~e_q[10], e_q[11] & ~e_q[10]};
    // Mirrors loads and software writes of both registers
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {m_q, e_q, q_is, q_rd, q_pc} <= 74'h0;
            since <= 8'hff;
        end
        else
        begin
            if (load_config_cmd && cmd_bank == 3'h0)
                m_q <= cmd_addr;
            else if (!load_config_cmd && psel && penable && pwrite && paddr == 12'h000)
                m_q <= pwdata[12:0];
            if (load_config_cmd && cmd_bank == 3'h1)
                e_q <= cmd_addr;
            else if (!load_config_cmd && psel && penable && pwrite && paddr == 12'h004)
                e_q <= pwdata[12:0];
            q_is <= (q_is >> 1) | ({15'h0, cmd_read} << al);
            q_rd <= (q_rd >> 1) | ({15'h0, cmd_read} << rl);
            q_pc <= (q_pc >> 1) | ({15'h0, wr_ap_last} << wr);
            since <= dll_reset_pulse ? 8'h0 : since + {7'h0, since != 8'hff};
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    AST_DLL_PULSE:
        assert property (load_config_cmd && cmd_bank == 3'h0 && cmd_addr[8] |-> ##2 dll_reset_pulse)
        else $error("dll reset pulse missing");
    AST_LOCK_WAIT:
        assert property (dll_locked |-> since >= DLL_LOCK_CYC - 1)
        else $error("dll locked too early");
    AST_RD_ISSUE:
        assert property (read_issue == q_is[0])
        else $error("internal read issue mistimed");
    AST_RD_DATA:
        assert property (read_data_start == q_rd[0])
        else $error("read data mistimed");
    AST_PRECHARGE:
        assert property (precharge_start == q_pc[0])
        else $error("auto precharge mistimed");
    AST_SLOW_EXIT:
        assert property ($fell(active_pd) && m_q[12] |=> exit_busy [*7] ##1 !exit_busy)
        else $error("slow exit length wrong");
    AST_FAST_EXIT:
        assert property (($fell(active_pd) && !m_q[12]) || $fell(precharge_pd)
            |=> exit_busy [*2] ##1 !exit_busy)
        else $error("fast exit length wrong");
    AST_OUT_OE:
        assert property ($past(presetn) |-> {dq_oe, dqs_n_oe, rcopy_n_oe} == $past(oe_x))
        else $error("output enables wrong");
    cover property (read_data_start);
    cover property (exit_busy && m_q[12]);
    cover property ($rose(dll_locked));
endmodule
bind smc_config smc_config_assertions #(.DLL_LOCK_CYC(DLL_LOCK_CYC)) chk_u (.*);

// ### test/tb.sv
`timescale 1ns/10ps
// ****
// Testbench
// ****
module tb;
    reg pclk = 0;
    reg presetn = 0;
    reg psel = 0;
    reg penable = 0;
    reg pwrite = 0;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0;
    reg self_refresh = 0;
    reg active_pd = 0;
    reg precharge_pd = 0;
    reg data_drive = 0;
    reg termination_ctrl_pin = 0;
    wire [31:0] prdata;
    wire [2:0] cmd_bank;
    wire [12:0] cmd_addr;
    wire [1:0] effective_termination;
    wire pready, pslverr, load_config_cmd, cmd_read, cmd_write, wr_ap_last, dll_enabled;
    wire dll_reset_pulse, dll_locked, dll_frozen, precharge_start, read_issue;
    wire read_data_start, write_data_start, exit_busy, drive_reduced, dq_oe;
    wire dqs_oe, dqs_n_oe, rcopy_oe, rcopy_n_oe, termination_on;
    wire [3:0] evs = {precharge_start, write_data_start, read_data_start, read_issue};
    int n_mismatch = 0;
    int n_checks = 0;
    int n, al, cl, wr, pd, mv;
    reg [31:0] r;
    reg err;
    reg [12:0] v;
    reg o;
    smc_config #(.DLL_LOCK_CYC(5)) dut_u (.*);
    smc_ctl_model #(.LOCK(5)) ctl_u (.*);
    task automatic chk(input string nm, input [31:0] seen, input [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic apb(input bit w, input [11:0] a, input [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic lat(input int s, input int x);
        ctl_u.pulse(s);
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while (n < 40 && evs[s] !== 1'b1);
        chk("latency", n, x);
    endtask
    task automatic pdx(input bit act, input int x);
        @(posedge pclk);
        {active_pd, precharge_pd} <= {act, !act};
        repeat (3) @(negedge pclk);
        chk("frozen", dll_frozen, act & pd[0]);
        @(posedge pclk);
        {active_pd, precharge_pd} <= 2'h0;
        n = 0;
        repeat (12)
        begin
            @(negedge pclk);
            n += (exit_busy === 1'b1);
        end
        chk("exit", n, x);
    endtask
    initial
    begin
        forever #2.5 pclk = ~pclk;
    end
    initial
    begin
        #100000;
        n_mismatch++;
        end_of_test;
    end
    initial
    begin
        void'($urandom(44991));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1, 12'h008, 32'hffffffff);
        apb(1, 12'h00c, 32'h1);
        apb(0, 12'h000, 0);
        chk("main", r, 0);
        apb(0, 12'h00c, 0);
        chk("unmapped", {err, r[30:0]}, 32'h80000000);
        repeat (6)
        begin
            al = $urandom % 7;
            cl = 3 + $urandom % 5;
            wr = 1 + $urandom % 7;
            pd = $urandom % 2;
            v = 13'($urandom) & 13'h1c46 | 13'(al << 3);
            mv = (pd << 12) | (wr << 9) | (cl << 4);
            apb(1, 12'h004, {19'h0, v ^ 13'h1c46});
            apb(0, 12'h004, 0);
            chk("ext sw", r, {19'h0, v ^ 13'h1c46});
            ctl_u.load(3'h1, v);
            ctl_u.load(3'h0, 13'(mv | 256));
            apb(0, 12'h000, 0);
            chk("main", r, mv);
            apb(0, 12'h004, 0);
            chk("ext", r, v);
            {data_drive, termination_ctrl_pin} <= 2'h3;
            repeat (4) @(negedge pclk);
            o = !v[12];
            chk("pins", {drive_reduced, dq_oe, dqs_oe, dqs_n_oe, rcopy_oe, rcopy_n_oe,
                effective_termination, termination_on}, {v[1], o, o, o & !v[10], o & v[11],
                o & v[11] & !v[10], v[6], v[2], v[6] | v[2]});
            @(posedge pclk);
            termination_ctrl_pin <= 1'b0;
            self_refresh <= 1'b1;
            repeat (4) @(negedge pclk);
            chk("refresh", {dll_enabled, termination_on}, 0);
            @(posedge pclk);
            self_refresh <= 1'b0;
            n = 0;
            do
            begin
                @(negedge pclk);
                n++;
            end
            while (n < 300 && dll_locked !== 1'b1);
            chk("relock", n >= 5 && n < 300, 1);
            lat(1, al + cl + 1);
            lat(2, al + cl);
            lat(0, al + 1);
            lat(3, wr + 2);
            pdx(1, pd ? 7 : 2);
            pdx(0, 2);
        end
        end_of_test;
    end
endmodule
